// ===== rtl/sgdc_map.svh
// Field positions, codes and reset values for the system and gate descriptor checker.
`ifndef SGDC_MAP_SVH
`define SGDC_MAP_SVH
`define SGDC_SEL_LEVEL_LO    0
`define SGDC_SEL_LEVEL_HI    1
`define SGDC_SEL_TABLE_BIT   2
`define SGDC_SEL_INDEX_LO    3
`define SGDC_SEL_INDEX_HI    15
`define SGDC_ACC_PRESENT     7
`define SGDC_ACC_PRIV_HI     6
`define SGDC_ACC_PRIV_LO     5
`define SGDC_ACC_SEG_BIT     4
`define SGDC_ACC_EXEC_BIT    3
`define SGDC_ACC_TYPE_HI     2
`define SGDC_ACC_TYPE_LO     0
`define SGDC_WCOUNT_HI       4
`define SGDC_WCOUNT_LO       0
`define SGDC_ENTRY_SHIFT     3
`define SGDC_EXC_NOT_PRESENT 8'h0b
`define SGDC_EXC_GENERAL     8'h0d
`define SGDC_EXC_NONE        8'h00
`define SGDC_RST_BASE        24'h000000
`define SGDC_RST_LIMIT       16'h0000
`define SGDC_RST_ACCESS      8'h00
`endif

// ===== rtl/sgdc_pkg.sv
// Types shared by the system and gate descriptor checker.
package sgdc_pkg;
  typedef enum logic [2:0] {
    SGDC_TYPE_BAD       = 3'b000,
    SGDC_TYPE_TASK_AVAIL = 3'b001,
    SGDC_TYPE_LOCAL_TBL  = 3'b010,
    SGDC_TYPE_TASK_BUSY  = 3'b011,
    SGDC_TYPE_CALL_GATE = 3'b100,
    SGDC_TYPE_TASK_GATE = 3'b101,
    SGDC_TYPE_INT_GATE  = 3'b110,
    SGDC_TYPE_TRAP_GATE = 3'b111
  } sgdc_type_e;
  typedef enum logic [1:0] {
    SGDC_SEG_CODE  = 2'b00,
    SGDC_SEG_STACK = 2'b01,
    SGDC_SEG_DATA  = 2'b10,
    SGDC_SEG_EXTRA = 2'b11
  } sgdc_segreg_e;
endpackage

// ===== rtl/sgdc_checker.sv
// System segment, gate and selector decoder with per-segment descriptor caches.
//
// Overview of operation
// R1 - Take 24-bit base, 16-bit limit
// R2 - Present flag one means descriptor valid
// R3 - Privilege field applies only to task segments
// R4 - Access bit 4 zero marks system descriptor
// R5 - Types 1-3: task available, table, busy
// R6 - Types 4-7: call, task, interrupt, trap gate
// R7 - Interrupt gate clears interrupt enable; trap keeps
// R8 - Wrong destination descriptor type raises exception 13
// R9 - Task gate offset ignored; others give entry
// R10 - Call gate copies 0-31 words on change
// R11 - Absent gate raises exception 11
// R12 - Four hidden caches, filled on register load
// R13 - Only code, data, stack descriptors cached
// R14 - Cache changes only on register reload
// R15 - Cache contents never readable by software
// R16 - Selector bits 1-0 give requested level
// R17 - Selector bit 2 chooses global or local
// R18 - Selector bits 15-3 give entry index
// R19 - Entry address is base plus eight times index
// R20 - Index beyond table limit raises exception 13
// R21 - System type zero raises exception 13

`timescale 1ns/1ns
`default_nettype none
`include "sgdc_map.svh"
module sgdc_checker
  import sgdc_pkg::*;
(
  // Clock and reset.
  input  wire logic        mclk,
  input  wire logic        srst,
  // Selector to translate.
  input  wire logic        sel_valid,
  input  wire logic [15:0] sel_value,
  input  wire logic [23:0] global_table_base,
  input  wire logic [15:0] global_table_limit,
  input  wire logic [23:0] local_table_base,
  input  wire logic [15:0] local_table_limit,
  // Fetched system or gate descriptor.
  input  wire logic        sys_valid,
  input  wire logic [7:0]  sys_access,
  input  wire logic [23:0] sys_base,
  input  wire logic [15:0] sys_limit,
  input  wire logic [15:0] gate_dest_sel,
  input  wire logic [15:0] gate_offset,
  input  wire logic [4:0]  gate_word_count,
  input  wire logic [7:0]  dest_access,
  input  wire logic        priv_change,
  input  wire logic        if_flag_in,
  // Segment register load and use.
  input  wire logic        seg_load,
  input  wire logic [1:0]  seg_select,
  input  wire logic [7:0]  seg_access,
  input  wire logic [23:0] seg_base,
  input  wire logic [15:0] seg_limit,
  input  wire logic [1:0]  use_select,
  // Selector results.
  output logic [12:0]      sel_index,
  output logic             sel_table_choice_bit,
  output logic [1:0]       selector_requested_level,
  output logic [23:0]      entry_address,
  output logic             sel_done,
  // System descriptor results.
  output logic             sys_done,
  output logic [2:0]       sys_type,
  output logic             sys_present,
  output logic [23:0]      sys_seg_base,
  output logic [15:0]      sys_seg_limit,
  output logic             sys_priv_used,
  output logic [1:0]       entry_privilege_level,
  output logic [15:0]      entry_offset,
  output logic [4:0]       copy_word_count,
  output logic             if_flag_out,
  output logic             task_switch,
  // Exceptions and cache.
  output logic             exc_valid,
  output logic [7:0]       exc_vector,
  output logic             cache_reject,
  output logic [23:0]      use_base,
  output logic [15:0]      use_limit,
  output logic [7:0]       use_access
);

  // Destination descriptor must be a code segment for call, interrupt and trap gates.
  function automatic logic is_code(input logic [7:0] acc);
    is_code = acc[`SGDC_ACC_SEG_BIT] && acc[`SGDC_ACC_EXEC_BIT];
  endfunction

  // Type field of an access byte, shared by the gate and destination checks.
  function automatic logic [2:0] acc_type(input logic [7:0] acc);
    acc_type = acc[`SGDC_ACC_TYPE_HI:`SGDC_ACC_TYPE_LO];
  endfunction

  // Destination descriptor must be a task state segment for task gates.
  // Both the available and the busy form count as a task state segment here;
  // whether a busy task may be entered is left to the task switch sequencing.
  function automatic logic is_task_seg(input logic [7:0] acc);
    is_task_seg = !acc[`SGDC_ACC_SEG_BIT] &&
                  ((acc_type(acc) == SGDC_TYPE_TASK_AVAIL) ||
                   (acc_type(acc) == SGDC_TYPE_TASK_BUSY));
  endfunction

  // Selector decode state.
  logic [12:0] next_sel_index;
  logic        next_sel_tbl;
  logic [1:0]  next_sel_level;
  logic [23:0] next_entry_address;
  logic        next_sel_done;
  logic        sel_fault;

  always_comb
  begin
    next_sel_index     = sel_value[`SGDC_SEL_INDEX_HI:`SGDC_SEL_INDEX_LO]; // [R18]
    next_sel_tbl       = sel_value[`SGDC_SEL_TABLE_BIT];                   // [R17]
    next_sel_level     = sel_value[`SGDC_SEL_LEVEL_HI:`SGDC_SEL_LEVEL_LO]; // [R16]
    next_sel_done      = sel_valid;
    // Table entries are eight bytes apart, so the index is scaled by eight.
    // The whole eight-byte entry must lie within the limit.
    if (next_sel_tbl)
    begin
      next_entry_address = local_table_base +
                           {8'h00, next_sel_index, 3'h0};                // [R19]
      sel_fault = ({3'h0, next_sel_index, 3'h7} > {3'h0, local_table_limit});  // [R20]
    end
    else
    begin
      next_entry_address = global_table_base + {8'h00, next_sel_index, 3'h0}; // [R19]
      sel_fault = ({3'h0, next_sel_index, 3'h7} > {3'h0, global_table_limit}); // [R20]
    end
  end

  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      sel_index                <= 13'h0000;
      sel_table_choice_bit     <= 1'b0;
      selector_requested_level <= 2'h0;
      entry_address            <= 24'h000000;
      sel_done                 <= 1'b0;
    end
    else
    begin
      sel_index                <= next_sel_index;
      sel_table_choice_bit     <= next_sel_tbl;
      selector_requested_level <= next_sel_level;
      entry_address            <= next_entry_address;
      sel_done                 <= next_sel_done;
    end
  end

  // System and gate descriptor decode state.
  logic [2:0]  next_type;
  logic        next_present;
  logic        next_priv_used;
  logic [15:0] next_offset;
  logic [4:0]  next_count;
  logic        next_if;
  logic        next_task_switch;
  logic        next_exc_valid;
  logic [7:0]  next_exc_vector;
  logic        is_system;
  logic        is_gate;

  always_comb
  begin
    next_type        = acc_type(sys_access);
    next_present     = sys_access[`SGDC_ACC_PRESENT];                      // [R2] [R11]
    is_system        = !sys_access[`SGDC_ACC_SEG_BIT];                     // [R4]
    is_gate          = next_type[2];                                       // [R6]
    // The privilege field matters only for task state segments; a local
    // table descriptor is used by a privileged load alone.
    next_priv_used   = (next_type == SGDC_TYPE_TASK_AVAIL) ||
                       (next_type == SGDC_TYPE_TASK_BUSY);                 // [R3] [R5]
    next_offset      = 16'h0000;
    next_count       = 5'h00;
    next_if          = if_flag_in;
    next_task_switch = 1'b0;
    next_exc_valid   = 1'b0;
    next_exc_vector  = `SGDC_EXC_NONE;
    // Faults are ranked: bad type, absent gate, wrong destination, and last
    // a selector beyond its table, so only one vector is ever reported.
    if (sys_valid)
    begin
      if (!is_system || next_type == SGDC_TYPE_BAD)
      begin
        next_exc_valid  = 1'b1;                                            // [R21]
        next_exc_vector = `SGDC_EXC_GENERAL;
      end
      else if (!next_present && is_gate)
      begin
        next_exc_valid  = 1'b1;                                            // [R11]
        next_exc_vector = `SGDC_EXC_NOT_PRESENT;
      end
      else if (is_gate)
      begin
        case (next_type)
          SGDC_TYPE_TASK_GATE:
          begin
            next_exc_valid   = !is_task_seg(dest_access);                  // [R8]
            next_task_switch = is_task_seg(dest_access);                   // [R9]
          end
          SGDC_TYPE_CALL_GATE:
          begin
            next_exc_valid = !is_code(dest_access);                        // [R8]
            next_offset    = gate_offset;                                  // [R9]
            next_count     = priv_change ? gate_word_count : 5'h00;        // [R10]
          end
          default:
          begin
            next_exc_valid = !is_code(dest_access);                        // [R8]
            next_offset    = gate_offset;                                  // [R9]
            if (next_type == SGDC_TYPE_INT_GATE && is_code(dest_access))
              next_if = 1'b0;                                              // [R7]
          end
        endcase
        if (next_exc_valid)
        begin
          next_offset      = 16'h0000;
          next_count       = 5'h00;
          next_if          = if_flag_in;
          next_exc_vector  = `SGDC_EXC_GENERAL;
        end
      end
    end
    if (!next_exc_valid && sel_valid && sel_fault)
    begin
      next_exc_valid  = 1'b1;                                              // [R20]
      next_exc_vector = `SGDC_EXC_GENERAL;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      sys_done              <= 1'b0;
      sys_type              <= 3'h0;
      sys_present           <= 1'b0;
      sys_seg_base          <= `SGDC_RST_BASE;
      sys_seg_limit         <= `SGDC_RST_LIMIT;
      sys_priv_used         <= 1'b0;
      entry_privilege_level <= 2'h0;
      entry_offset          <= 16'h0000;
      copy_word_count       <= 5'h00;
      if_flag_out           <= 1'b0;
      task_switch           <= 1'b0;
      exc_valid             <= 1'b0;
      exc_vector            <= `SGDC_EXC_NONE;
    end
    else
    begin
      sys_done              <= sys_valid;
      sys_type              <= next_type;
      sys_present           <= next_present;
      sys_seg_base          <= sys_base;                                   // [R1]
      sys_seg_limit         <= sys_limit;                                  // [R1]
      sys_priv_used         <= next_priv_used;
      entry_privilege_level <= sys_access[`SGDC_ACC_PRIV_HI:`SGDC_ACC_PRIV_LO];
      entry_offset          <= next_offset;
      copy_word_count       <= next_count;
      if_flag_out           <= next_if;
      task_switch           <= sys_valid && next_task_switch;
      exc_valid             <= next_exc_valid;
      exc_vector            <= next_exc_vector;
    end
  end

  // Hidden descriptor caches, one per segment register; no port writes them
  // except a segment load, and only the use path reads them.
  logic [23:0] cache_base   [4];
  logic [15:0] cache_limit  [4];
  logic [7:0]  cache_access [4];
  logic        load_ok;
  logic        next_reject;

  // A rejected load leaves every cache as it was and only raises the pulse.
  always_comb
  begin
    load_ok     = seg_load && seg_access[`SGDC_ACC_SEG_BIT];               // [R13]
    next_reject = seg_load && !seg_access[`SGDC_ACC_SEG_BIT];              // [R13]
  end

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++)
    begin : g_cache
      logic [23:0] next_base;
      logic [15:0] next_limit;
      logic [7:0]  next_access;
      always_comb
      begin
        next_base   = cache_base[gi];
        next_limit  = cache_limit[gi];
        next_access = cache_access[gi];
        if (load_ok && seg_select == 2'(gi))
        begin
          next_base   = seg_base;                                          // [R12]
          next_limit  = seg_limit;
          next_access = seg_access;
        end
      end
      always_ff @(posedge mclk)
      begin
        if (srst)
        begin
          cache_base[gi]   <= `SGDC_RST_BASE;
          cache_limit[gi]  <= `SGDC_RST_LIMIT;
          cache_access[gi] <= `SGDC_RST_ACCESS;
        end
        else
        begin
          cache_base[gi]   <= next_base;                                   // [R14]
          cache_limit[gi]  <= next_limit;
          cache_access[gi] <= next_access;
        end
      end
    end
  endgenerate

  // The caches are read only here, one cycle after the select, so software
  // never sees more than the use path hands on.
  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      cache_reject <= 1'b0;
      use_base     <= `SGDC_RST_BASE;
      use_limit    <= `SGDC_RST_LIMIT;
      use_access   <= `SGDC_RST_ACCESS;
    end
    else
    begin
      cache_reject <= next_reject;
      use_base     <= cache_base[use_select];                              // [R14] [R15]
      use_limit    <= cache_limit[use_select];
      use_access   <= cache_access[use_select];
    end
  end

endmodule // sgdc_checker
`default_nettype wire

// ===== tb/sgdc_checker_monitor.sv
// Port-level assertions for the descriptor checker.
`timescale 1ns/1ns
`default_nettype none
module sgdc_checker_monitor
(
  // Clock and reset.
  input wire logic        mclk,
  input wire logic        srst,
  // Requests.
  input wire logic        sel_valid,
  input wire logic [15:0] sel_value,
  input wire logic [23:0] global_table_base,
  input wire logic [15:0] global_table_limit,
  input wire logic [23:0] local_table_base,
  input wire logic [15:0] local_table_limit,
  input wire logic        sys_valid,
  input wire logic [7:0]  sys_access,
  input wire logic [15:0] gate_offset,
  input wire logic [4:0]  gate_word_count,
  input wire logic [7:0]  dest_access,
  input wire logic        priv_change,
  input wire logic        if_flag_in,
  input wire logic        seg_load,
  input wire logic [7:0]  seg_access,
  // Results.
  input wire logic [12:0] sel_index,
  input wire logic        sel_table_choice_bit,
  input wire logic [1:0]  selector_requested_level,
  input wire logic [23:0] entry_address,
  input wire logic        exc_valid,
  input wire logic [7:0]  exc_vector,
  input wire logic        cache_reject,
  input wire logic [4:0]  copy_word_count,
  input wire logic        if_flag_out,
  input wire logic        task_switch,
  input wire logic [15:0] entry_offset
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst);
  wire logic [2:0]  ty    = sys_access[2:0];
  wire logic        gate  = sys_valid && !sys_access[4] && sys_access[2];
  wire logic        tgate = ty == 3'h5;
  wire logic        dbad  = tgate ? (dest_access[4] || dest_access[2] || !dest_access[0])
                                  : !(dest_access[4] && dest_access[3]);
  wire logic [23:0] tbase = sel_value[2] ? local_table_base : global_table_base;
  wire logic [15:0] tlim  = sel_value[2] ? local_table_limit : global_table_limit;
  sequence s_good_gate;
    gate && sys_access[7] && !dbad;
  endsequence
  property p_sel_split;
    sel_valid |=> {sel_index, sel_table_choice_bit, selector_requested_level} == $past(sel_value);
  endproperty
  a_sel_split: assert property (p_sel_split) else $error("selector split wrong");
  property p_entry;
    sel_valid |=> entry_address == $past(tbase) + {8'h00, $past(sel_value[15:3]), 3'h0};
  endproperty
  a_entry: assert property (p_entry) else $error("entry address wrong");
  property p_over;
    sel_valid && !sys_valid && {sel_value[15:3], 3'h7} > tlim |=> exc_valid && exc_vector == 8'h0d;
  endproperty
  a_over: assert property (p_over) else $error("limit fault missing");
  property p_bad_type;
    sys_valid && (sys_access[4] || ty == 3'h0) |=> exc_valid && exc_vector == 8'h0d;
  endproperty
  a_bad_type: assert property (p_bad_type) else $error("bad type accepted");
  property p_absent;
    gate && !sys_access[7] |=> exc_valid && exc_vector == 8'h0b;
  endproperty
  a_absent: assert property (p_absent) else $error("absent gate fault missing");
  property p_dest;
    gate && sys_access[7] && dbad |=> exc_valid && exc_vector == 8'h0d;
  endproperty
  a_dest: assert property (p_dest) else $error("destination fault missing");
  property p_if;
    s_good_gate |=> if_flag_out == ($past(ty) != 3'h6 && $past(if_flag_in));
  endproperty
  a_if: assert property (p_if) else $error("interrupt flag wrong");
  property p_wcount;
    s_good_gate |=> copy_word_count ==
      (($past(ty) == 3'h4 && $past(priv_change)) ? $past(gate_word_count) : 5'h0);
  endproperty
  a_wcount: assert property (p_wcount) else $error("word count wrong");
  property p_task;
    s_good_gate |=> task_switch == $past(tgate) &&
      entry_offset == ($past(tgate) ? 16'h0 : $past(gate_offset));
  endproperty
  a_task: assert property (p_task) else $error("entry offset wrong");
  property p_reject;
    seg_load && !seg_access[4] |=> cache_reject;
  endproperty
  a_reject: assert property (p_reject) else $error("system descriptor cached");
endmodule // sgdc_checker_monitor
bind sgdc_checker sgdc_checker_monitor sgdc_checker_monitor_i (.*);
`default_nettype wire

// ===== tb/sgdc_desc_table.sv
// Descriptor table in system memory that feeds segment register loads.
`timescale 1ns/1ns
`default_nettype none
module sgdc_desc_table
(
  // Read request.
  input  wire logic       rd_en,
  input  wire logic [2:0] rd_index,
  // Descriptor fields.
  output logic [7:0]      acc,
  output logic [23:0]     base,
  output logic [15:0]     lim
);
  logic [47:0] word;
  // Entries 6 and 7 hold system descriptors; the bus shows garbage when idle.
  always_comb
  begin
    word = {rd_index[2:1] == 2'b11 ? 8'h81 : {5'h12, rd_index}, rd_index, 21'h0a5a5a,
            rd_index, 13'h0fff};
    {acc, base, lim} = rd_en ? word : ~word;
  end
endmodule // sgdc_desc_table
`default_nettype wire

// ===== tb/sgdc_checker_test.sv
// Self-checking testbench for the system and gate descriptor checker.
`timescale 1ns/1ns
`default_nettype none
`include "sgdc_map.svh"
`define CHK(got, exp) begin samples_checked++; if ((got) !== (exp)) begin fails++; \
  $display("[FAIL] %0t got %0h expected %0h", $time, got, exp); end end
module sgdc_checker_test
  import sgdc_pkg::*;
;
  logic        mclk = 0, srst = 1, sel_valid = 0, sys_valid = 0, priv_change = 0;
  logic        if_flag_in = 0, seg_load = 0, sel_table_choice_bit, sel_done, sys_done;
  logic        sys_present, sys_priv_used, if_flag_out, task_switch, exc_valid, cache_reject;
  logic [15:0] sel_value = 0, global_table_limit = 0, local_table_limit = 0, sys_limit = 0;
  logic [15:0] gate_dest_sel = 0, gate_offset = 0, seg_limit, sys_seg_limit, entry_offset;
  logic [15:0] use_limit;
  logic [23:0] global_table_base = 0, local_table_base = 0, sys_base = 0, seg_base;
  logic [23:0] entry_address, sys_seg_base, use_base;
  logic [7:0]  sys_access = 0, dest_access = 0, seg_access, exc_vector, use_access;
  logic [4:0]  gate_word_count = 0, copy_word_count;
  logic [1:0]  seg_select = 0, use_select = 0, selector_requested_level, entry_privilege_level;
  logic [2:0]  tbl_idx = 0, sys_type;
  logic [12:0] sel_index;
  logic [47:0] shadow [4];
  logic [7:0]  dtab [4] = '{8'h9a, 8'h81, 8'h92, 8'h86};
  int          fails = 0, samples_checked = 0;
  sgdc_checker sgdc_checker_i (.*);
  sgdc_desc_table sgdc_desc_table_i (.rd_en(seg_load), .rd_index(tbl_idx), .acc(seg_access),
                                     .base(seg_base), .lim(seg_limit));
  always #20 mclk = ~mclk;
  task automatic test_done();
    $display("fails=%0d samples_checked=%0d", fails, samples_checked);
    if (fails == 0 && samples_checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic run_sel(input logic [15:0] s, input logic [15:0] lim);
    sel_value = s;
    global_table_limit = lim;
    local_table_limit = ~lim;
    global_table_base = 24'($urandom);
    local_table_base = 24'($urandom);
    sel_valid = 1'b1;
    @(negedge mclk);
    `CHK(sel_done, 1'b1)
    `CHK({sel_index, sel_table_choice_bit, selector_requested_level}, s)
    `CHK(entry_address, (s[2] ? local_table_base : global_table_base) + {8'h00, s[15:3], 3'h0})
    `CHK({exc_valid, exc_vector}, {s[15:3], 3'h7} > (s[2] ? ~lim : lim) ? 9'h10d : 9'h000)
  endtask
  task automatic run_sys(input logic [7:0] a, input logic [7:0] d);
    logic [2:0] t;
    logic       bad, dbad;
    logic [8:0] ex;
    t = a[2:0];
    sys_access = a;
    dest_access = d;
    sys_base = 24'($urandom);
    sys_limit = 16'($urandom);
    gate_offset = 16'($urandom);
    gate_word_count = 5'($urandom);
    gate_dest_sel = 16'($urandom);
    priv_change = 1'($urandom);
    if_flag_in = 1'($urandom);
    sys_valid = 1'b1;
    bad = a[4] || t == 3'h0;
    dbad = t == SGDC_TYPE_TASK_GATE ? (d[4] || d[2] || !d[0]) : !(d[4] && d[3]);
    ex = bad ? {1'b1, `SGDC_EXC_GENERAL} : (t[2] && !a[7]) ? {1'b1, `SGDC_EXC_NOT_PRESENT}
       : (t[2] && dbad) ? {1'b1, `SGDC_EXC_GENERAL} : 9'h000;
    @(negedge mclk);
    `CHK(sys_done, 1'b1)
    `CHK({exc_valid, exc_vector}, ex)
    if (!bad) `CHK(sys_type, t)
    `CHK(entry_privilege_level, a[6:5])
    if (!bad && !t[2]) `CHK({sys_seg_base, sys_seg_limit, sys_present, sys_priv_used},
                            {sys_base, sys_limit, a[7], t[0]})
    if (t[2] && ex == 9'h000) `CHK({if_flag_out, copy_word_count, task_switch, entry_offset},
      {t != 3'h6 && if_flag_in, (t == 3'h4 && priv_change) ? gate_word_count : 5'h0,
       t == 3'h5, t == 3'h5 ? 16'h0 : gate_offset})
  endtask
  task automatic load(input logic [1:0] r, input logic [2:0] k);
    logic [47:0] w;
    w = {k[2:1] == 2'b11 ? 8'h81 : {5'h12, k}, k, 21'h0a5a5a, k, 13'h0fff};
    seg_select = r;
    tbl_idx = k;
    seg_load = 1'b1;
    if (w[44])
      shadow[r] = w;
    @(negedge mclk);
    `CHK(cache_reject, ~w[44])
  endtask
  initial
  begin
    void'($urandom(18467));
    repeat (5) @(negedge mclk);
    srst = 1'b0;
    @(negedge mclk);
    run_sel(16'h0000, 16'h0007);
    run_sel(16'h0008, 16'h0007);
    run_sel(16'hffff, 16'h0000);
    repeat (40) run_sel(16'($urandom), 16'($urandom));
    sel_valid = 1'b0;
    for (int i = 0; i < 64; i++)
      run_sys({i[3], 2'($urandom), i[5] & i[4], 1'b0, i[2:0]}, dtab[i[5:4]]);
    repeat (30) run_sys(8'($urandom) & 8'hf7, dtab[2'($urandom)]);
    run_sys(8'h85, 8'h83);
    run_sys(8'he5, 8'h92);
    sys_valid = 1'b0;
    for (int r = 0; r < 4; r++)
      load(2'(r), 3'($urandom_range(5)));
    load(2'h2, 3'h6);
    repeat (20) load(2'($urandom), 3'($urandom));
    seg_load = 1'b0;
    repeat (10) @(negedge mclk);
    for (int r = 0; r < 4; r++)
    begin
      use_select = 2'(r);
      @(negedge mclk);
      `CHK({use_access, use_base, use_limit}, shadow[r])
    end
    test_done();
  end
endmodule // sgdc_checker_test
`default_nettype wire
